// ==== modmap_map.svh ====
// Purpose: Offsets, field positions and key values of the module map bank
// Assumes: Register indices are word indices; byte address is index times four
// Notes:   Included by the bank and its descriptor formatter
`ifndef MODMAP_MAP_SVH
`define MODMAP_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices
`define IDX_BLOCK1      14'h2030
`define IDX_BLOCK2      14'h2031
`define IDX_BLOCK3      14'h2032
`define IDX_BLOCK4      14'h2033
`define IDX_CURSOR      14'h2038
`define IDX_COUNT       14'h2039
`define IDX_SWRST       14'h2040
`define IDX_FLFMT       14'h2041
`define IDX_EXTRACT     14'h2042
`define IDX_FACTORY     14'h2043
`define IDX_STATUS      14'h2044

////////////////////////////////////////////////////////////////////////////////
// Block geometry
`define BLK_WORDS       7'h40
`define BLK4_WORDS      7'h3F
`define FIRST_MODULE    8'h41
`define MEM_DEPTH       191

////////////////////////////////////////////////////////////////////////////////
// Descriptor field positions
`define DF_IN           0
`define DF_OUT          1
`define DF_SIZE_LO      8
`define DF_SIZE_HI      14
`define DF_DIGITAL      15

////////////////////////////////////////////////////////////////////////////////
// Command keys and bus answers
`define KEY_A           16'hAA55
`define KEY_B           16'h55AA
`define STATUS_REJ_BIT  4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== modmap_pkg.sv ====
// Purpose: Types shared by the module map bank and its formatter
// Assumes: AXI4-Lite with 16-bit byte addresses and 32-bit data
// Notes:   All bank state except the descriptor memory lives in one packed struct
package modmap_pkg;

    typedef struct packed {
        logic        awvalid;
        logic [15:0] awaddr;
        logic [2:0]  awprot;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [15:0] araddr;
        logic [2:0]  arprot;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  module_num;
        logic        digital;
        logic        is_input;
        logic        is_output;
        logic [6:0]  size_bits;
        logic [15:0] raw_word;
    } desc_wr_t;

    typedef struct packed {
        logic factory;
        logic extract;
        logic flash_format;
        logic soft_reset;
    } cmd_t;

    typedef struct packed {
        axil_rsp_t       rsp;
        logic            aw_got;
        logic [13:0]     aw_idx;
        logic            w_got;
        logic [15:0]     w_data;
        logic [1:0]      w_strb;
        logic [2:0][6:0] cursor;
        cmd_t            pulse;
        cmd_t            pending;
        logic            key_reject;
    } modmap_state_t;

endpackage

// ==== desc_format.sv ====
// Purpose: Builds the descriptor word of one I/O module
// Assumes: Digital modules carry no readable order number
// Notes:   Purely combinational
`include "modmap_map.svh"

module desc_format (
    input  wire modmap_pkg::desc_wr_t i_desc,
    output logic [15:0]               o_word
);
    import modmap_pkg::*;

    always_comb begin
        o_word = 16'h0000;
        if (i_desc.digital) begin
            o_word[`DF_IN]                   = i_desc.is_input;  // RULE4
            o_word[`DF_OUT]                  = i_desc.is_output; // RULE4
            o_word[`DF_SIZE_HI:`DF_SIZE_LO]  = i_desc.size_bits; // RULE4
            o_word[`DF_DIGITAL]              = 1'b1;             // RULE4
        end else begin
            // Complex modules report their own identity word
            o_word = i_desc.raw_word; // RULE5
        end
    end

endmodule

// ==== module_map_regs.sv ====
// Purpose: Module descriptor blocks 2 to 4 and key-protected command registers
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   Descriptor blocks are read through per-block auto-advancing cursors
//
// Functional notes
// RULE1 - Block two returns one word per present module 65 to 128, up to 64 words.
// RULE2 - Block three returns one word per present module 129 to 192, up to 64 words.
// RULE3 - Block four returns one word per present module 193 to 255, up to 63 words.
// RULE4 - A digital module word has input bit 0, output bit 1, size in 14:8, marker 15.
// RULE5 - Digital modules show the coded word instead of an order number.
// RULE6 - Key 0xAA55 or 0x55AA at the reset command register starts a software reset.
// RULE7 - Key 0xAA55 or 0x55AA at the format command register reformats the flash.
// RULE8 - A valid key at the extract command register unpacks the web files to flash.
// RULE9 - Writing 0x55AA to the factory command register restores factory settings.
// RULE10 - Block one holds the controller word and modules 1 to 64, served elsewhere.
// RULE11 - Any other value written to a command register is ignored; the code still sets key_reject, read back at status bit 4.
`include "modmap_map.svh"

module module_map_regs #(
    parameter logic [6:0] BLK_WORDS  = `BLK_WORDS,
    parameter logic [6:0] BLK4_WORDS = `BLK4_WORDS
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire modmap_pkg::axil_req_t i_axi,
    output modmap_pkg::axil_rsp_t      o_axi,
    input  wire modmap_pkg::desc_wr_t  i_desc,
    input  wire logic [7:0]            i_module_count,
    input  wire modmap_pkg::cmd_t      i_cmd_done,
    output modmap_pkg::cmd_t           o_cmd_pulse,
    output modmap_pkg::cmd_t           o_cmd_pending
);
    import modmap_pkg::*;

    modmap_state_t s;
    modmap_state_t next_s;

    logic [15:0]   desc_mem [0:`MEM_DEPTH-1];
    logic [15:0]   desc_word;
    logic [7:0]    desc_slot;
    logic          desc_in_range;

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor store
    desc_format u_format (
        .i_desc (i_desc),
        .o_word (desc_word)
    );

    // Module numbers below the first slot belong to block one
    assign desc_slot     = i_desc.module_num - `FIRST_MODULE; // RULE10
    assign desc_in_range = (i_desc.module_num >= `FIRST_MODULE);

    always_ff @(posedge i_clk) begin
        if (i_desc.valid && desc_in_range) begin
            desc_mem[desc_slot] <= desc_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode helpers
    logic [13:0]   rd_idx;
    logic          rd_is_block;
    logic [1:0]    rd_blk;
    logic [6:0]    rd_cur;
    logic [6:0]    rd_lim;
    logic [7:0]    rd_module;
    logic [7:0]    rd_slot;
    logic          rd_present;
    logic [15:0]   rd_desc;

    always_comb begin
        rd_idx      = i_axi.araddr[15:2];
        rd_is_block = 1'b0;
        rd_blk      = 2'd0;
        if (rd_idx == `IDX_BLOCK2) begin
            rd_is_block = 1'b1; // RULE1
            rd_blk      = 2'd0;
        end else if (rd_idx == `IDX_BLOCK3) begin
            rd_is_block = 1'b1; // RULE2
            rd_blk      = 2'd1;
        end else if (rd_idx == `IDX_BLOCK4) begin
            rd_is_block = 1'b1; // RULE3
            rd_blk      = 2'd2;
        end
    end

    always_comb begin
        rd_cur     = s.cursor[rd_blk];
        rd_lim     = (rd_blk == 2'd2) ? BLK4_WORDS : BLK_WORDS; // RULE3
        // Each block starts 64 modules after the previous one
        rd_module  = `FIRST_MODULE + {rd_blk[1:0], 6'h00} + {1'b0, rd_cur}; // RULE1
        rd_slot    = rd_module - `FIRST_MODULE;
        rd_present = (rd_cur < rd_lim) && (rd_module <= i_module_count);
        rd_desc    = 16'h0000;
        if (rd_present) begin
            rd_desc = desc_mem[rd_slot]; // RULE2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode helpers
    logic          wr_fire;
    logic          wr_full_word;
    logic          wr_key_any;
    logic          wr_key_factory;
    logic          wr_is_cmd;
    logic          wr_known;
    cmd_t          wr_cmd;

    always_comb begin
        wr_fire        = s.aw_got && s.w_got;
        wr_full_word   = (s.w_strb == 2'b11);
        wr_key_any     = wr_full_word && ((s.w_data == `KEY_A) || (s.w_data == `KEY_B));
        wr_key_factory = wr_full_word && (s.w_data == `KEY_B); // RULE9
        wr_cmd         = '0;
        wr_is_cmd      = 1'b0;
        wr_known       = 1'b0;
        if (s.aw_idx == `IDX_SWRST) begin
            wr_is_cmd          = 1'b1;
            wr_cmd.soft_reset  = wr_key_any; // RULE6
        end else if (s.aw_idx == `IDX_FLFMT) begin
            wr_is_cmd            = 1'b1;
            wr_cmd.flash_format  = wr_key_any; // RULE7
        end else if (s.aw_idx == `IDX_EXTRACT) begin
            wr_is_cmd       = 1'b1;
            wr_cmd.extract  = wr_key_any; // RULE8
        end else if (s.aw_idx == `IDX_FACTORY) begin
            wr_is_cmd       = 1'b1;
            wr_cmd.factory  = wr_key_factory; // RULE9
        end else if (s.aw_idx == `IDX_CURSOR) begin
            wr_known = 1'b1;
        end else if (s.aw_idx == `IDX_STATUS) begin
            wr_known = 1'b1;
        end else if (s.aw_idx == `IDX_COUNT) begin
            wr_known = 1'b1;
        end else if (s.aw_idx == `IDX_BLOCK2) begin
            wr_known = 1'b1;
        end else if (s.aw_idx == `IDX_BLOCK3) begin
            wr_known = 1'b1;
        end else if (s.aw_idx == `IDX_BLOCK4) begin
            wr_known = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s       = s;
        next_s.pulse = '0;

        // Completion from the executing side clears pending; new command wins
        next_s.pending = s.pending & ~i_cmd_done;

        // Write address and data channels, taken in either order
        if (i_axi.awvalid && s.rsp.awready) begin
            next_s.aw_got      = 1'b1;
            next_s.aw_idx      = i_axi.awaddr[15:2];
            next_s.rsp.awready = 1'b0;
        end
        if (i_axi.wvalid && s.rsp.wready) begin
            next_s.w_got      = 1'b1;
            next_s.w_data     = i_axi.wdata[15:0];
            next_s.w_strb     = i_axi.wstrb[1:0];
            next_s.rsp.wready = 1'b0;
        end

        // Both halves present: act and answer
        if (wr_fire) begin
            next_s.aw_got     = 1'b0;
            next_s.w_got      = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp  = (wr_is_cmd || wr_known) ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_is_cmd) begin
                // Wrong keys leave every command untouched
                next_s.pulse   = wr_cmd; // RULE11
                next_s.pending = next_s.pending | wr_cmd;
            end
            if (s.aw_idx == `IDX_CURSOR && s.w_strb[0]) begin
                next_s.cursor[0] = s.w_data[6:0];
                next_s.cursor[1] = s.w_data[6:0];
                next_s.cursor[2] = s.w_data[6:0];
            end
            if (s.aw_idx == `IDX_STATUS && s.w_strb[0] && s.w_data[`STATUS_REJ_BIT]) begin
                next_s.key_reject = 1'b0;
            end
            if (wr_is_cmd && (wr_cmd == '0)) begin
                next_s.key_reject = 1'b1; // RULE11
            end
        end

        // Write response taken: reopen both write channels
        if (s.rsp.bvalid && i_axi.bready) begin
            next_s.rsp.bvalid  = 1'b0;
            next_s.rsp.bresp   = `RESP_OKAY;
            next_s.rsp.awready = 1'b1;
            next_s.rsp.wready  = 1'b1;
        end

        // Read address taken: data next cycle, block cursor advances
        if (i_axi.arvalid && s.rsp.arready) begin
            next_s.rsp.arready = 1'b0;
            next_s.rsp.rvalid  = 1'b1;
            next_s.rsp.rresp   = `RESP_OKAY;
            next_s.rsp.rdata   = 32'h0000_0000;
            if (rd_is_block) begin
                next_s.rsp.rdata[15:0] = rd_desc;
                // Wraps so the next burst of reads starts at the first module
                if (rd_cur + 7'd1 >= rd_lim) begin
                    next_s.cursor[rd_blk] = 7'd0;
                end else begin
                    next_s.cursor[rd_blk] = rd_cur + 7'd1;
                end
            end else if (rd_idx == `IDX_CURSOR) begin
                next_s.rsp.rdata[20:0] = {s.cursor[2], s.cursor[1], s.cursor[0]};
            end else if (rd_idx == `IDX_COUNT) begin
                next_s.rsp.rdata[7:0] = i_module_count;
            end else if (rd_idx == `IDX_STATUS) begin
                next_s.rsp.rdata[4:0] = {s.key_reject, s.pending};
            end else if (rd_idx == `IDX_SWRST || rd_idx == `IDX_FLFMT) begin
                next_s.rsp.rdata = 32'h0000_0000;
            end else if (rd_idx == `IDX_EXTRACT || rd_idx == `IDX_FACTORY) begin
                next_s.rsp.rdata = 32'h0000_0000;
            end else begin
                next_s.rsp.rresp = `RESP_SLVERR;
            end
        end

        // Read data taken: accept the next read address
        if (s.rsp.rvalid && i_axi.rready) begin
            next_s.rsp.rvalid  = 1'b0;
            next_s.rsp.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s             <= '0;
            s.rsp.awready <= 1'b1;
            s.rsp.wready  <= 1'b1;
            s.rsp.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_axi         = s.rsp;
    assign o_cmd_pulse   = s.pulse;
    assign o_cmd_pending = s.pending;

endmodule

// ==== modmap_assertions.sv ====
// Purpose: Port checks for the module map bank
// Assumes: Only the top ports are visible
// Notes:   Helper regs keep the last address and data taken
`include "modmap_map.svh"

module modmap_chk #(
    parameter logic [6:0] BLK_WORDS  = `BLK_WORDS,
    parameter logic [6:0] BLK4_WORDS = `BLK4_WORDS
) (
    input wire logic                  i_clk,
    input wire logic                  i_srst,
    input wire modmap_pkg::axil_req_t i_axi,
    input wire modmap_pkg::axil_rsp_t o_axi,
    input wire modmap_pkg::cmd_t      o_cmd_pulse
);
    import modmap_pkg::*;
    logic [13:0] ai;
    logic [13:0] ri;
    logic [15:0] wd;
    logic        full;
    logic        key_b;

    always_ff @(posedge i_clk) begin
        if (i_axi.awvalid && o_axi.awready)
            ai <= i_axi.awaddr[15:2];
        if (i_axi.arvalid && o_axi.arready)
            ri <= i_axi.araddr[15:2];
        if (i_axi.wvalid && o_axi.wready) begin
            wd    <= i_axi.wdata[15:0];
            full  <= i_axi.wstrb[1:0] == 2'h3;
        end
    end
    assign key_b = full && wd == `KEY_B;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    swrst_key_a: assert property (o_cmd_pulse.soft_reset |-> o_axi.bvalid &&
        ai == `IDX_SWRST && full && (wd == `KEY_A || key_b)) else $error("reset pulse bad");
    flfmt_key_a: assert property (o_cmd_pulse.flash_format |-> o_axi.bvalid &&
        ai == `IDX_FLFMT && full && (wd == `KEY_A || key_b)) else $error("format pulse bad");
    extract_key_a: assert property (o_cmd_pulse.extract |-> o_axi.bvalid &&
        ai == `IDX_EXTRACT && full && (wd == `KEY_A || key_b)) else $error("extract pulse bad");
    factory_key_a: assert property (o_cmd_pulse.factory |-> o_axi.bvalid &&
        ai == `IDX_FACTORY && key_b) else $error("factory pulse bad");
    key_ignore_a: assert property ($rose(o_axi.bvalid) && ai >= `IDX_SWRST &&
        ai <= `IDX_FACTORY && !(full && (wd == `KEY_A || key_b)) |-> o_cmd_pulse == '0)
        else $error("pulse on wrong key");
    cmd_fire_a: assert property ($rose(o_axi.bvalid) && ai >= `IDX_SWRST &&
        ai <= `IDX_EXTRACT && full && (wd == `KEY_A || key_b) |-> $onehot(o_cmd_pulse))
        else $error("key write gave no pulse");
    read_answer_a: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
        else $error("read not answered");
    desc_word_a: assert property (o_axi.rvalid && ri >= `IDX_BLOCK2 && ri <= `IDX_BLOCK4
        |-> o_axi.rdata[31:16] == 16'h0 && (!o_axi.rdata[15] || o_axi.rdata[7:2] == 6'h0))
        else $error("descriptor word malformed");
    block1_refused_a: assert property (o_axi.rvalid && ri == `IDX_BLOCK1 |->
        o_axi.rresp == `RESP_SLVERR) else $error("block one answered");

    factory_c: cover property (o_cmd_pulse.factory);
    desc_c: cover property (o_axi.rvalid && o_axi.rdata[15]);
    slverr_c: cover property (o_axi.rvalid && o_axi.rresp == `RESP_SLVERR);
endmodule

bind module_map_regs modmap_chk #(.BLK_WORDS(BLK_WORDS), .BLK4_WORDS(BLK4_WORDS)) i_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_axi(i_axi), .o_axi(o_axi), .o_cmd_pulse(o_cmd_pulse));

// ==== axil_master_model.sv ====
// Purpose: Fieldbus master issuing single register words over AXI4-Lite
// Assumes: One write and one read at a time
// Notes:   Released address and data lines show the inverse of the last value
module axil_master_model (
    input  wire logic                  i_clk,
    output modmap_pkg::axil_req_t      o_req,
    input  wire modmap_pkg::axil_rsp_t i_rsp
);
    import modmap_pkg::*;
    initial o_req = '0;

    task automatic write_word(input logic [13:0] idx, input logic [31:0] d,
                              input logic [3:0] strb, output logic [1:0] resp);
        int n;
        resp = 2'bxx;
        // Let the previous release settle before a new request
        @(posedge i_clk);
        o_req.awvalid <= 1'b1;
        o_req.awaddr  <= {idx, 2'h0};
        o_req.wvalid  <= 1'b1;
        o_req.wdata   <= d;
        o_req.wstrb   <= strb;
        o_req.bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge i_clk);
            if (o_req.awvalid && i_rsp.awready) begin
                o_req.awvalid <= 1'b0;
                o_req.awaddr  <= ~o_req.awaddr;
            end
            if (o_req.wvalid && i_rsp.wready) begin
                o_req.wvalid <= 1'b0;
                o_req.wdata  <= ~o_req.wdata;
            end
            if (i_rsp.bvalid) begin
                resp = i_rsp.bresp;
                o_req.bready <= 1'b0;
                break;
            end
        end
        if (n == 64)
            tb_top.hang();
    endtask

    task automatic read_word(input logic [13:0] idx, output logic [31:0] d,
                             output logic [1:0] resp);
        int n;
        resp = 2'bxx;
        @(posedge i_clk);
        o_req.arvalid <= 1'b1;
        o_req.araddr  <= {idx, 2'h0};
        o_req.rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge i_clk);
            if (o_req.arvalid && i_rsp.arready)
                o_req.arvalid <= 1'b0;
            if (i_rsp.rvalid) begin
                d    = i_rsp.rdata;
                resp = i_rsp.rresp;
                o_req.rready <= 1'b0;
                o_req.araddr <= ~o_req.araddr;
                break;
            end
        end
        if (n == 64)
            tb_top.hang();
    endtask
endmodule

// ==== tb_top.sv ====
// Purpose: Descriptor reads and key-protected commands of the module map bank
// Assumes: Bus tasks live in the master model
// Notes:   Command pulses are sampled at the write answer
`include "modmap_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import modmap_pkg::*;
    logic        clk;
    logic        srst;
    axil_req_t   req;
    axil_rsp_t   rsp;
    desc_wr_t    desc;
    logic [7:0]  count;
    cmd_t        done;
    cmd_t        pulse;
    cmd_t        pend;
    logic [31:0] rd;
    logic [1:0]  resp;
    logic [15:0] keys [3] = '{16'h1234, `KEY_A, `KEY_B};
    int          miscompares;
    int          samples_checked;

    module_map_regs i_dut (.i_clk(clk), .i_srst(srst), .i_axi(req), .o_axi(rsp),
        .i_desc(desc), .i_module_count(count), .i_cmd_done(done),
        .o_cmd_pulse(pulse), .o_cmd_pending(pend));
    axil_master_model i_master (.i_clk(clk), .o_req(req), .i_rsp(rsp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Wide enough for a response code beside a full data word
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic hang;
        miscompares++;
        final_report();
    endtask

    task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
        i_master.read_word(idx, rd, resp);
        check({resp, rd}, {`RESP_OKAY, exp});
    endtask

    // Pulse seen in the answer cycle, then answer code
    task automatic cmd(input logic [13:0] idx, input logic [15:0] d, input logic [3:0] s,
                       input logic [3:0] exp);
        i_master.write_word(idx, {16'h0, d}, s, resp);
        check({resp, pulse}, {`RESP_OKAY, exp});
    endtask

    task automatic load(input logic [7:0] n, input logic [2:0] f, input logic [6:0] s,
                        input logic [15:0] r);
        @(posedge clk);
        desc <= {1'b1, n, f, s, r};
        @(posedge clk);
        desc.valid <= 1'b0;
    endtask

    initial begin
        srst  = 1'b1;
        desc  = '0;
        count = 8'h0;
        done  = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        load(8'h41, 3'h6, 7'h4, 16'h0);
        load(8'h42, 3'h0, 7'h0, 16'h1234);
        load(8'h80, 3'h6, 7'h1, 16'h0);
        load(8'h81, 3'h5, 7'h2, 16'hFFFF);
        load(8'hC1, 3'h7, 7'h8, 16'h0);
        load(8'hFF, 3'h5, 7'h7F, 16'h0);
        count <= 8'h42;
        rd_chk(`IDX_BLOCK2, 32'h0000_8401);
        rd_chk(`IDX_BLOCK2, 32'h0000_1234);
        rd_chk(`IDX_BLOCK2, 32'h0);
        rd_chk(`IDX_BLOCK3, 32'h0);
        count <= 8'hFF;
        cmd(`IDX_CURSOR, 16'h0, 4'hF, 4'h0);
        rd_chk(`IDX_BLOCK3, 32'h0000_8202);
        rd_chk(`IDX_BLOCK4, 32'h0000_8803);
        cmd(`IDX_CURSOR, 16'h3F, 4'hF, 4'h0);
        rd_chk(`IDX_BLOCK2, 32'h0000_8101);
        rd_chk(`IDX_BLOCK2, 32'h0000_8401);
        rd_chk(`IDX_BLOCK4, 32'h0);
        cmd(`IDX_CURSOR, 16'h3E, 4'hF, 4'h0);
        rd_chk(`IDX_BLOCK4, 32'h0000_FF02);
        rd_chk(`IDX_BLOCK4, 32'h0000_8803);
        i_master.read_word(`IDX_BLOCK1, rd, resp);
        check(resp, `RESP_SLVERR);
        i_master.write_word(`IDX_BLOCK1, 32'h0000_0000, 4'hF, resp);
        check(resp, `RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 3; k++) begin
                cmd(`IDX_SWRST + 14'(i), keys[k], 4'hF,
                    (k == 0 || (i == 3 && k == 1)) ? 4'h0 : 4'(1 << i));
            end
        end
        cmd(`IDX_SWRST, `KEY_B, 4'h1, 4'h0);
        check(pend, 4'hF);
        done <= 4'hF;
        @(posedge clk);
        done <= 4'h0;
        @(posedge clk);
        check(pend, 4'h0);
        rd_chk(`IDX_STATUS, 32'h10);
        final_report();
    end
endmodule
